// *** logic/homing_defines.vh ***
// Purpose: Offsets, reset values and method codes for the homing control block
// Assumes: Included by its bare name
// Notes: Definitions only
`ifndef HOMING_DEFINES_VH
`define HOMING_DEFINES_VH
`define OFS_METHOD_SELECT 16'h1b18
`define OFS_OFFSET_DIST 16'h280e
`define OFS_PREF_METHOD 16'h2814
`define OFS_HOME_POS 16'h2816
`define RST_METHOD 16'h0012
`define RST_OFFSET_DIST 32'h000000c8
`define RST_HOME_POS 32'h00000000
`define M_LIM_NEG_IDX 8'h01
`define M_LIM_POS_IDX 8'h02
`define M_REFP_IDX_LO 8'h07
`define M_REFP_IDX_HI 8'h0a
`define M_REFN_IDX_LO 8'h0b
`define M_REFN_IDX_HI 8'h0e
`define M_LIM_NEG 8'h11
`define M_LIM_POS 8'h12
`define M_REFP_LO 8'h17
`define M_REFP_HI 8'h1a
`define M_REFN_LO 8'h1b
`define M_REFN_HI 8'h1e
`define M_IDX_NEG 8'h1f
`define M_IDX_POS 8'h22
`define M_POS_SET 8'h23
`define KIND_NONE 3'h0
`define KIND_LIMIT 3'h1
`define KIND_REF 3'h2
`define KIND_INDEX 3'h3
`define KIND_SET 3'h4
`endif

// *** logic/homing_method_control.v ***
// Purpose: Parameter registers and termination logic for homing mode
// Assumes: Registers reached by a simple address/strobe port; motion engine outside
// Notes: Nonvolatile store is modelled by an external load/save handshake
`timescale 1ns/1ps
`include "homing_defines.vh"
module homing_method_control
(
    // Clock and reset
    input wire SYS_CLK,
    input wire RST,
    // Register port
    input wire REG_WR,
    input wire REG_RD,
    input wire [15:0] REG_ADDR,
    input wire [31:0] REG_WDATA,
    output reg [31:0] REG_RDATA,
    output reg REG_ACK,
    // Nonvolatile store
    input wire NV_VALID,
    input wire [15:0] NV_METHOD,
    output reg NV_SAVE,
    output reg [15:0] NV_SAVE_DATA,
    // Mode control from motion engine
    input wire HOME_START,
    input wire MOTOR_STANDSTILL,
    input wire REF_REACHED,
    input wire [31:0] SWITCH_POS,
    input wire HALT_REQ,
    input wire QSTOP_REQ,
    input wire ERROR_DET,
    // Movement setup out
    output reg [2:0] MOVE_KIND,
    output reg MOVE_DIR_POS,
    output reg MOVE_USE_INDEX,
    output reg MOVE_INVERT,
    output reg MOVE_OUTSIDE,
    output reg [31:0] MOVE_OFFSET,
    output reg MOVE_BUSY,
    // Position result
    output reg POS_LOAD,
    output reg [31:0] POS_VALUE,
    output reg [31:0] REF_POINT,
    output reg ZERO_VALID,
    output reg MODE_DONE
);
    localparam ST_IDLE = 2'h0;
    localparam ST_MOVE = 2'h1;
    localparam ST_STOP = 2'h2;
    reg [15:0] method_select;
    reg [15:0] pref_method;
    reg [31:0] offset_dist;
    reg [31:0] home_pos;
    reg [31:0] offset_run;
    reg [31:0] home_run;
    reg [1:0] state;
    reg good;
    reg nv_done;
    reg [1:0] nv_sync;
    wire [2:0] kind;
    wire dir_pos;
    wire use_index;
    wire invert;
    wire outside;

    ////////////////////////////////////////////////////////////////////////////
    // decode live selector
    homing_method_decode u_decode
    (
        .code(method_select),
        .kind(kind),
        .dir_pos(dir_pos),
        .use_index(use_index),
        .invert(invert),
        .outside(outside)
    );

    function in_range;
        input [15:0] v;
        begin
            in_range = (v >= {8'h00, `M_LIM_NEG_IDX}) && (v <= {8'h00, `M_POS_SET});
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Register file
    always @(posedge SYS_CLK or posedge RST)
    begin
        if (RST)
        begin
            method_select <= `RST_METHOD;
            pref_method <= `RST_METHOD;
            offset_dist <= `RST_OFFSET_DIST;
            home_pos <= `RST_HOME_POS;
            REG_RDATA <= 32'h00000000;
            REG_ACK <= 1'b0;
            NV_SAVE <= 1'b0;
            NV_SAVE_DATA <= 16'h0000;
            nv_done <= 1'b0;
            nv_sync <= 2'h0;
        end
        else
        begin
            REG_ACK <= REG_WR | REG_RD;
            NV_SAVE <= 1'b0;
            nv_sync <= {nv_sync[0], NV_VALID};
            if (nv_sync[1] && !nv_done)
            begin
                nv_done <= 1'b1;
                if (in_range(NV_METHOD))
                begin
                    pref_method <= NV_METHOD;
                    method_select <= NV_METHOD;
                end
            end
            if (REG_WR)
            begin
                case (REG_ADDR)
                    `OFS_METHOD_SELECT:
                        if (in_range(REG_WDATA[15:0]))
                            method_select <= REG_WDATA[15:0];
                    `OFS_PREF_METHOD:
                        if (in_range(REG_WDATA[15:0]))
                        begin
                            pref_method <= REG_WDATA[15:0];
                            NV_SAVE <= 1'b1;
                            NV_SAVE_DATA <= REG_WDATA[15:0];
                        end
                    // Minimum offset is one unit
                    `OFS_OFFSET_DIST:
                        if (!REG_WDATA[31] && REG_WDATA != 32'h00000000)
                            offset_dist <= REG_WDATA;
                    `OFS_HOME_POS:
                        home_pos <= REG_WDATA;
                    default:
                        offset_dist <= offset_dist;
                endcase
            end
            case (REG_ADDR)
                `OFS_METHOD_SELECT:
                    REG_RDATA <= {16'h0000, method_select};
                `OFS_PREF_METHOD:
                    REG_RDATA <= {16'h0000, pref_method};
                `OFS_OFFSET_DIST:
                    REG_RDATA <= offset_dist;
                `OFS_HOME_POS:
                    REG_RDATA <= home_pos;
                default:
                    REG_RDATA <= 32'h00000000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Mode sequence; stop requests override a same-cycle success
    always @(posedge SYS_CLK or posedge RST)
    begin
        if (RST)
        begin
            state <= ST_IDLE;
            good <= 1'b0;
            offset_run <= `RST_OFFSET_DIST;
            home_run <= `RST_HOME_POS;
            MOVE_KIND <= `KIND_NONE;
            MOVE_DIR_POS <= 1'b0;
            MOVE_USE_INDEX <= 1'b0;
            MOVE_INVERT <= 1'b0;
            MOVE_OUTSIDE <= 1'b0;
            MOVE_OFFSET <= 32'h00000000;
            MOVE_BUSY <= 1'b0;
            POS_LOAD <= 1'b0;
            POS_VALUE <= 32'h00000000;
            REF_POINT <= 32'h00000000;
            ZERO_VALID <= 1'b0;
            MODE_DONE <= 1'b0;
        end
        else
        begin
            POS_LOAD <= 1'b0;
            MODE_DONE <= 1'b0;
            // selection tracks at once while idle
            if (state == ST_IDLE)
            begin
                MOVE_KIND <= kind;
                MOVE_DIR_POS <= dir_pos;
                MOVE_USE_INDEX <= use_index;
                MOVE_INVERT <= invert;
                MOVE_OUTSIDE <= outside;
            end
            case (state)
                ST_IDLE:
                    if (HOME_START && kind != `KIND_NONE)
                    begin
                        if (kind == `KIND_SET)
                        begin
                            POS_LOAD <= 1'b1;
                            POS_VALUE <= home_pos;
                            ZERO_VALID <= 1'b1;
                            MODE_DONE <= 1'b1;
                        end
                        else
                        begin
                            offset_run <= offset_dist;
                            home_run <= home_pos;
                            MOVE_OFFSET <= use_index ? 32'h00000000 : offset_dist;
                            MOVE_BUSY <= 1'b1;
                            good <= 1'b0;
                            ZERO_VALID <= 1'b0;
                            state <= ST_MOVE;
                        end
                    end
                ST_MOVE:
                    if (HALT_REQ || QSTOP_REQ || ERROR_DET)
                    begin
                        good <= 1'b0;
                        state <= ST_STOP;
                    end
                    else if (REF_REACHED)
                    begin
                        good <= 1'b1;
                        REF_POINT <= MOVE_USE_INDEX ? SWITCH_POS : (MOVE_DIR_POS ^ MOVE_INVERT ^ ~MOVE_OUTSIDE
                            ? SWITCH_POS + offset_run : SWITCH_POS - offset_run);
                        state <= ST_STOP;
                    end
                ST_STOP:
                    begin
                        if (HALT_REQ || QSTOP_REQ || ERROR_DET)
                            good <= 1'b0;
                        if (MOTOR_STANDSTILL)
                        begin
                            state <= ST_IDLE;
                            MOVE_BUSY <= 1'b0;
                            MODE_DONE <= 1'b1;
                            if (good && !(HALT_REQ || QSTOP_REQ || ERROR_DET))
                            begin
                                POS_LOAD <= 1'b1;
                                POS_VALUE <= home_run;
                                ZERO_VALID <= 1'b1;
                            end
                            else
                                ZERO_VALID <= 1'b0;
                        end
                    end
                default:
                    state <= ST_IDLE;
            endcase
        end
    end
endmodule

// *** logic/homing_method_decode.v ***
// Purpose: Decode a homing method code into movement attributes
// Assumes: Pure combinational
// Notes: Unknown codes give kind none
`timescale 1ns/1ps
`include "homing_defines.vh"
module homing_method_decode
(
    // Code in
    input wire [15:0] code,
    // Attributes out
    output reg [2:0] kind,
    output reg dir_pos,
    output reg use_index,
    output reg invert,
    output reg outside
);
    reg [7:0] c;
    reg [1:0] v;
    always @*
    begin
        c = code[7:0];
        v = 2'h0;
        kind = `KIND_NONE;
        dir_pos = 1'b0;
        use_index = 1'b0;
        invert = 1'b0;
        outside = 1'b0;
        if (code[15:8] == 8'h00)
        begin
            if (c == `M_LIM_NEG_IDX || c == `M_LIM_POS_IDX || c == `M_LIM_NEG || c == `M_LIM_POS)
            begin
                kind = `KIND_LIMIT;
                dir_pos = (c == `M_LIM_POS_IDX) || (c == `M_LIM_POS);
                use_index = (c == `M_LIM_NEG_IDX) || (c == `M_LIM_POS_IDX);
            end
            else if ((c >= `M_REFP_IDX_LO && c <= `M_REFP_IDX_HI) || (c >= `M_REFP_LO && c <= `M_REFP_HI))
            begin
                kind = `KIND_REF;
                dir_pos = 1'b1;
                use_index = (c <= `M_REFP_IDX_HI);
                v = use_index ? c[1:0] + 2'h1 : c[1:0] + 2'h1;
            end
            else if ((c >= `M_REFN_IDX_LO && c <= `M_REFN_IDX_HI) || (c >= `M_REFN_LO && c <= `M_REFN_HI))
            begin
                kind = `KIND_REF;
                use_index = (c <= `M_REFN_IDX_HI);
                v = c[1:0] + 2'h1;
            end
            else if (c == `M_IDX_NEG || c == `M_IDX_POS)
            begin
                kind = `KIND_INDEX;
                dir_pos = (c == `M_IDX_POS);
                use_index = 1'b1;
            end
            else if (c == `M_POS_SET)
                kind = `KIND_SET;
        end
        // variant: 0 inv out, 1 inv in, 2 not inv in, 3 not inv out
        if (kind == `KIND_REF)
        begin
            invert = ~v[1];
            outside = (v == 2'h0) || (v == 2'h3);
        end
    end
endmodule

// *** test/homing_checker_assertions.sv ***
// Purpose: Port checker for the homing control block
// Assumes: One clock domain, reset active high
// Notes: Figures follow the port timing of the block
`timescale 1ns/1ps
`include "homing_defines.vh"
module homing_checker
(
    // Clock and reset
    input wire SYS_CLK,
    input wire RST,
    // Watched ports
    input wire REG_WR,
    input wire [15:0] REG_ADDR,
    input wire [31:0] REG_WDATA,
    input wire NV_SAVE,
    input wire HOME_START,
    input wire MOTOR_STANDSTILL,
    input wire HALT_REQ,
    input wire QSTOP_REQ,
    input wire ERROR_DET,
    input wire [2:0] MOVE_KIND,
    input wire MOVE_USE_INDEX,
    input wire [31:0] MOVE_OFFSET,
    input wire MOVE_BUSY,
    input wire POS_LOAD,
    input wire ZERO_VALID,
    input wire MODE_DONE
);
default clocking cb @(posedge SYS_CLK); endclocking
default disable iff (RST);
wire stop_any = HALT_REQ | QSTOP_REQ | ERROR_DET;
////////////////////////////////////////////////////////////////
sequence s_set_wr;
    REG_WR && REG_ADDR == `OFS_METHOD_SELECT && REG_WDATA == 32'h23 && !MOVE_BUSY && !HOME_START;
endsequence
sequence s_set_seen;
    ##[1:3] MOVE_KIND == `KIND_SET;
endsequence
property p_sel_now; s_set_wr |-> s_set_seen; endproperty
property p_done_still; MODE_DONE |-> $past(MOTOR_STANDSTILL); endproperty
// Abort must not end in a load within four cycles after it, even with the reference found late
property p_abort; MOVE_BUSY && stop_any |=> (!POS_LOAD && !ZERO_VALID) [*4]; endproperty
property p_start_clear; $rose(MOVE_BUSY) |-> !ZERO_VALID; endproperty
property p_set_still; POS_LOAD && MOVE_KIND == `KIND_SET |-> !MOVE_BUSY && !$past(MOVE_BUSY); endproperty
property p_load; POS_LOAD |-> ZERO_VALID && MODE_DONE; endproperty
property p_hold; MOVE_BUSY && $past(MOVE_BUSY) |-> $stable(MOVE_OFFSET); endproperty
property p_idx; MOVE_BUSY && MOVE_USE_INDEX |-> MOVE_OFFSET == 32'h0; endproperty
property p_nv; REG_WR && REG_ADDR == `OFS_PREF_METHOD && REG_WDATA == 32'h1a |-> ##[1:3] NV_SAVE; endproperty
a_sel_now: assert property (p_sel_now) else $error("selector not applied");
a_done_still: assert property (p_done_still) else $error("done while moving");
a_abort: assert property (p_abort) else $error("load after abort");
a_start_clear: assert property (p_start_clear) else $error("zero valid kept");
a_set_still: assert property (p_set_still) else $error("setting moved");
a_load: assert property (p_load) else $error("load without valid");
a_hold: assert property (p_hold) else $error("offset changed in move");
a_idx: assert property (p_idx) else $error("offset used with index");
a_nv: assert property (p_nv) else $error("no store request");
endmodule
bind homing_method_control homing_checker u_chk (.SYS_CLK(SYS_CLK), .RST(RST), .REG_WR(REG_WR),
    .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .NV_SAVE(NV_SAVE), .HOME_START(HOME_START),
    .MOTOR_STANDSTILL(MOTOR_STANDSTILL), .HALT_REQ(HALT_REQ), .QSTOP_REQ(QSTOP_REQ), .ERROR_DET(ERROR_DET),
    .MOVE_KIND(MOVE_KIND), .MOVE_USE_INDEX(MOVE_USE_INDEX), .MOVE_OFFSET(MOVE_OFFSET),
    .MOVE_BUSY(MOVE_BUSY), .POS_LOAD(POS_LOAD), .ZERO_VALID(ZERO_VALID), .MODE_DONE(MODE_DONE));

// *** test/motion_partner.sv ***
// Purpose: Motion engine stand-in
// Assumes: Starts on a rising busy
// Notes: Stops at once on any abort
`timescale 1ns/1ps
module motion_partner
(
    // Clock and reset
    input wire clk,
    input wire rst,
    // Engine side
    input wire busy,
    input wire stop,
    input wire [31:0] sw_pos,
    output reg ref_reached,
    output reg [31:0] switch_pos,
    output reg standstill
);
reg [3:0] cnt;
reg busy_q;
always @(posedge clk or posedge rst)
begin
    if (rst)
    begin
        cnt <= 4'h0;
        busy_q <= 1'b0;
        ref_reached <= 1'b0;
        switch_pos <= 32'h0;
        standstill <= 1'b1;
    end
    else
    begin
        busy_q <= busy;
        ref_reached <= 1'b0;
        // Position is stale outside the report, so keep it moving
        switch_pos <= ~switch_pos;
        cnt <= standstill ? 4'h0 : cnt + 4'h1;
        if (busy && !busy_q)
            standstill <= 1'b0;
        if (!standstill && cnt == 4'h5 && !stop)
        begin
            ref_reached <= 1'b1;
            switch_pos <= sw_pos;
        end
        if (!standstill && (stop || cnt == 4'h9))
            standstill <= 1'b1;
    end
end
endmodule

// *** test/tb_top.sv ***
// Purpose: Self-checking bench for homing control
// Assumes: Inputs change 2 ns after the rising edge
// Notes: The bench plays the nonvolatile store
`timescale 1ns/1ps
`include "homing_defines.vh"
module tb_top;
reg sys_clk = 1'b0;
reg rst = 1'b1;
reg reg_wr = 1'b0, reg_rd = 1'b0, nv_valid = 1'b0, home_start = 1'b0;
reg [15:0] reg_addr = 16'h0, nv_method = 16'h0012;
reg [31:0] reg_wdata = 32'h0, sw = 32'h00001000, d;
reg [2:0] stp = 3'h0;
wire [31:0] reg_rdata, move_offset, pos_value, ref_point, switch_pos;
wire [15:0] nv_save_data;
wire [2:0] move_kind;
wire reg_ack, nv_save, ref_reached, standstill, move_dir_pos, move_use_index, move_invert, move_outside;
wire move_busy, pos_load, zero_valid, mode_done;
integer failures = 0, checked = 0, i;
always #12.5 sys_clk = ~sys_clk;
homing_method_control uut (.SYS_CLK(sys_clk), .RST(rst), .REG_WR(reg_wr), .REG_RD(reg_rd),
    .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata), .REG_ACK(reg_ack),
    .NV_VALID(nv_valid), .NV_METHOD(nv_method), .NV_SAVE(nv_save), .NV_SAVE_DATA(nv_save_data),
    .HOME_START(home_start), .MOTOR_STANDSTILL(standstill), .REF_REACHED(ref_reached),
    .SWITCH_POS(switch_pos), .HALT_REQ(stp[0]), .QSTOP_REQ(stp[1]), .ERROR_DET(stp[2]),
    .MOVE_KIND(move_kind), .MOVE_DIR_POS(move_dir_pos), .MOVE_USE_INDEX(move_use_index),
    .MOVE_INVERT(move_invert), .MOVE_OUTSIDE(move_outside), .MOVE_OFFSET(move_offset),
    .MOVE_BUSY(move_busy), .POS_LOAD(pos_load), .POS_VALUE(pos_value), .REF_POINT(ref_point),
    .ZERO_VALID(zero_valid), .MODE_DONE(mode_done));
motion_partner u_motion (.clk(sys_clk), .rst(rst), .busy(move_busy), .stop(|stp), .sw_pos(sw),
    .ref_reached(ref_reached), .switch_pos(switch_pos), .standstill(standstill));
// Store keeps whatever the block asks to save
always @(posedge sys_clk)
    if (nv_save === 1'b1)
        nv_method <= nv_save_data;
////////////////////////////////////////////////////////////////
task results;
begin
    if (failures == 0 && checked > 0)
        $display("Run complete: PASS");
    else
        $display("Run complete: FAIL");
    $finish;
end
endtask
task chk(input [31:0] got, input [31:0] exp);
begin
    checked = checked + 1;
    if (got !== exp)
    begin
        failures = failures + 1;
        $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
end
endtask
task tick;
begin
    @(posedge sys_clk);
    #2;
end
endtask
task wr(input [15:0] a, input [31:0] v);
begin
    reg_addr = a;
    reg_wdata = v;
    reg_wr = 1'b1;
    tick;
    reg_wr = 1'b0;
    tick;
end
endtask
task rdc(input [15:0] a, input [31:0] exp);
begin
    reg_addr = a;
    reg_rd = 1'b1;
    tick;
    reg_rd = 1'b0;
    chk(reg_rdata, exp);
    chk({31'h0, reg_ack}, 32'h1);
    tick;
end
endtask
task home_go;
begin
    home_start = 1'b1;
    tick;
    home_start = 1'b0;
end
endtask
task home_run;
begin
    home_go;
    for (i = 0; i < 40 && mode_done !== 1'b1; i = i + 1)
        tick;
    chk(32'(mode_done), 32'h1);
end
endtask
function [6:0] attr(input [7:0] c);
reg [7:0] k;
begin
    k = (c >= 8'd23 ? c - 8'd23 : c - 8'd7) % 8'd4;
    attr = 7'h0;
    if (c == 8'd1 || c == 8'd2 || c == 8'd17 || c == 8'd18)
        attr = {`KIND_LIMIT, c == 8'd2 || c == 8'd18, c < 8'd3, 2'h0};
    if ((c >= 8'd7 && c <= 8'd14) || (c >= 8'd23 && c <= 8'd30))
        attr = {`KIND_REF, c <= 8'd10 || c >= 8'd23 && c <= 8'd26, c <= 8'd14, k < 8'd2, k == 8'd0 || k == 8'd3};
    if (c == 8'd31 || c == 8'd34)
        attr = {`KIND_INDEX, c == 8'd34, 3'h4};
    if (c == 8'd35)
        attr = {`KIND_SET, 4'h0};
end
endfunction
task move_case(input [31:0] m, input [31:0] off, input [31:0] eoff, input [31:0] eref, input [31:0] ehome);
begin
    wr(`OFS_OFFSET_DIST, off);
    wr(`OFS_METHOD_SELECT, m);
    home_go;
    // Changes during the move must not reach this run
    wr(`OFS_OFFSET_DIST, 32'h1);
    wr(`OFS_HOME_POS, m);
    chk(move_offset, eoff);
    tick;
    for (i = 0; i < 40 && mode_done !== 1'b1; i = i + 1)
        tick;
    chk({mode_done, pos_load, zero_valid}, 32'h7);
    chk(pos_value, ehome);
    chk(ref_point, eref);
end
endtask
////////////////////////////////////////////////////////////////
initial
begin
    repeat (20) @(posedge sys_clk);
    #2;
    rst = 1'b0;
    rdc(`OFS_METHOD_SELECT, 32'h12);
    rdc(`OFS_PREF_METHOD, 32'h12);
    rdc(`OFS_OFFSET_DIST, 32'hc8);
    rdc(`OFS_HOME_POS, 32'h0);
    rdc(16'h0000, 32'h0);
    for (d = 1; d <= 35; d = d + 1)
    begin
        wr(`OFS_METHOD_SELECT, d);
        tick;
        chk({move_kind, move_dir_pos, move_use_index, move_invert, move_outside}, attr(d[7:0]));
    end
    wr(`OFS_METHOD_SELECT, 32'h24);
    wr(`OFS_METHOD_SELECT, 32'h0);
    rdc(`OFS_METHOD_SELECT, 32'h23);
    wr(`OFS_OFFSET_DIST, 32'h0);
    rdc(`OFS_OFFSET_DIST, 32'hc8);
    wr(`OFS_HOME_POS, 32'h1234);
    home_run;
    chk({pos_load, zero_valid, move_busy}, 32'h6);
    chk(pos_value, 32'h1234);
    wr(`OFS_PREF_METHOD, 32'h1a);
    nv_valid = 1'b1;
    rst = 1'b1;
    repeat (3) tick;
    rst = 1'b0;
    repeat (5) tick;
    rdc(`OFS_METHOD_SELECT, 32'h1a);
    rdc(`OFS_PREF_METHOD, 32'h1a);
    move_case(32'h1a, 32'h32, 32'h32, sw + 32'h32, 32'h0);
    move_case(32'h17, 32'h63, 32'h63, sw - 32'h63, 32'h1a);
    move_case(32'h07, 32'h5, 32'h0, sw, 32'h17);
    for (d = 0; d < 3; d = d + 1)
    begin
        home_go;
        stp = 3'h1 << d;
        tick;
        for (i = 0; i < 40 && mode_done !== 1'b1; i = i + 1)
            tick;
        stp = 3'h0;
        chk({mode_done, pos_load, zero_valid}, 32'h4);
    end
    results;
end
initial
begin
    #150000;
    failures = failures + 1;
    results;
end
endmodule
